// ### design/crcb_map.svh
// register map and constants of the byte-wise crc engine
`ifndef CRCB_MAP_SVH
`define CRCB_MAP_SVH
`define CRCB_ADDR_CONTROL 8'h92
`define CRCB_ADDR_BYTE_INPUT 8'h93
`define CRCB_ADDR_RESULT_DATA 8'h91
`define CRCB_CONTROL_RESET 8'h00
`define CRCB_BYTE_INPUT_RESET 8'h00
`define CRCB_BIT_POLY_SEL 4
`define CRCB_BIT_INIT 3
`define CRCB_BIT_INIT_VAL 2
`define CRCB_PTR_MSB 1
`define CRCB_POLY16 16'h1021
`define CRCB_POLY32_REFL 32'hedb88320
`define CRCB_INIT_ZERO 32'h00000000
`define CRCB_INIT_ONES 32'hffffffff
`endif

// ### design/crcb_pkg.sv
// types of the byte-wise crc engine
package crcb_pkg;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} crcb_sfr_req_t;
	typedef struct packed {
		logic poly16;
		logic init_ones;
		logic [1:0] ptr;
	} crcb_ctrl_t;
	typedef enum logic {
		CRCB_IDLE,
		CRCB_BUSY
	} crcb_mode_t;
endpackage

// ### design/crcb_fifo.sv
// small first-in first-out buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module crcb_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// drain side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	// refused at elaboration: the pointers wrap by overflow, so only powers of two work
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
		$error("crcb_fifo: depth must be a power of two of at least 2");
	end
	typedef struct packed {
		logic [AW-1:0] rp;
		logic [AW-1:0] wp;
		logic [AW:0] cnt;
	} st_t;
	st_t s, next_s;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push, pop;
	assign in_ready = s.cnt != (AW+1)'(DEPTH);
	assign out_valid = s.cnt != '0;
	assign out_data = mem[s.rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_comb begin
		next_s = s;
		if (push)
			next_s.wp = s.wp + 1'b1;
		if (pop)
			next_s.rp = s.rp + 1'b1;
		next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			s <= '0;
		else
			s <= next_s;
	end
	always_ff @(posedge core_clk) begin
		if (push)
			mem[s.wp] <= in_data;
	end
endmodule
`default_nettype wire

// ### design/crcb_engine.sv
// byte-wise crc engine: control register, byte input and result data port
`timescale 1ns/100ps
`default_nettype none
`include "crcb_map.svh"
module crcb_engine
	import crcb_pkg::*;
#(
	parameter int FIFO_DEPTH = 4
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// special function register access
	input wire crcb_sfr_req_t sfr_req,
	output logic [7:0] sfr_rdata,
	// a byte is queued and folds on the next edge
	output logic busy,
	// input ready, back-pressure towards the register writer
	output logic in_ready
);
	if (FIFO_DEPTH != 4) begin
		$error("crcb_engine: byte queue is sized for four entries");
	end
	typedef struct packed {
		crcb_ctrl_t ctrl;
		logic [7:0] in_reg;
		logic [31:0] result;
		logic [7:0] rdata;
		logic busy;
		logic in_ready;
		crcb_mode_t mode;
	} st_t;
	st_t s, next_s;
	logic q_valid, q_in_ready;
	logic [7:0] q_data;
	logic wr_ctrl, wr_in, acc_dat;
	logic [1:0] sel;
	logic [31:0] folded;
	logic [7:0] cur_byte;

	assign wr_ctrl = sfr_req.wr && sfr_req.addr == `CRCB_ADDR_CONTROL;
	assign wr_in = sfr_req.wr && sfr_req.addr == `CRCB_ADDR_BYTE_INPUT;
	assign acc_dat = (sfr_req.wr || sfr_req.rd) && sfr_req.addr == `CRCB_ADDR_RESULT_DATA;

	// byte queue between the register write and the fold logic
	// drained every cycle so no later init or result write can be overtaken by an older byte
	crcb_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.core_clk(core_clk),
		.rst(rst),
		.in_valid(wr_in),
		.in_data(sfr_req.wdata),
		.in_ready(q_in_ready),
		.out_valid(q_valid),
		.out_data(q_data),
		.out_ready(1'b1)
	);

	// fold one byte into a result
	function automatic logic [31:0] fold(input logic [31:0] r, input logic [7:0] b, input logic p16);
		logic [31:0] a;
		logic [15:0] h;
		a = r;
		h = r[15:0];
		if (p16) begin
			h = h ^ {b, 8'h00};
			for (int i = 0; i < 8; i++) begin
				if (h[15])
					h = {h[14:0], 1'b0} ^ `CRCB_POLY16;
				else
					h = {h[14:0], 1'b0};
			end
			a = {r[31:16], h};
		end else begin
			a = a ^ {24'h000000, b};
			for (int i = 0; i < 8; i++) begin
				if (a[0])
					a = (a >> 1) ^ `CRCB_POLY32_REFL;
				else
					a = a >> 1;
			end
		end
		return a;
	endfunction

	always_comb begin
		next_s = s;
		// sixteen-bit mode aliases pointer bit 1
		sel = s.ctrl.poly16 ? {1'b0, s.ctrl.ptr[0]} : s.ctrl.ptr;
		folded = fold(s.result, q_data, s.ctrl.poly16);
		// pending byte folds first, ahead of any access in the same cycle
		if (q_valid)
			next_s.result = folded;
		// pointer picks one of four bytes, one of two in sixteen-bit mode, seen after the pending fold
		cur_byte = next_s.result[8*sel +: 8];
		if (wr_in)
			next_s.in_reg = sfr_req.wdata;
		if (wr_ctrl) begin
			next_s.ctrl.poly16 = sfr_req.wdata[`CRCB_BIT_POLY_SEL];
			next_s.ctrl.init_ones = sfr_req.wdata[`CRCB_BIT_INIT_VAL];
			next_s.ctrl.ptr = sfr_req.wdata[`CRCB_PTR_MSB:0];
			if (sfr_req.wdata[`CRCB_BIT_INIT])
				next_s.result = sfr_req.wdata[`CRCB_BIT_INIT_VAL] ? `CRCB_INIT_ONES : `CRCB_INIT_ZERO;
		end
		if (acc_dat) begin
			if (sfr_req.wr)
				next_s.result[8*sel +: 8] = sfr_req.wdata;
			next_s.ctrl.ptr = s.ctrl.ptr + 2'b01;
		end
		next_s.rdata = 8'h00;
		if (sfr_req.addr == `CRCB_ADDR_CONTROL)
			next_s.rdata = {3'b000, s.ctrl.poly16, 1'b0, s.ctrl.init_ones, s.ctrl.ptr};
		else if (sfr_req.addr == `CRCB_ADDR_BYTE_INPUT)
			next_s.rdata = s.in_reg;
		else if (sfr_req.addr == `CRCB_ADDR_RESULT_DATA)
			next_s.rdata = cur_byte;
		// queue drains every cycle, so it holds a byte only right after a push
		next_s.mode = (wr_in && q_in_ready) ? CRCB_BUSY : CRCB_IDLE;
		next_s.busy = next_s.mode == CRCB_BUSY;
		next_s.in_ready = q_in_ready;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s <= '0;
			s.in_ready <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign sfr_rdata = s.rdata;
	assign busy = s.busy;
	assign in_ready = s.in_ready;
endmodule
`default_nettype wire

// ### dv/crcb_monitor.sv
// port assertions of the crc engine
`timescale 1ns/100ps
`default_nettype none
module crcb_monitor
	import crcb_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// register access
	input wire crcb_sfr_req_t sfr_req,
	input wire logic [7:0] sfr_rdata,
	// status
	input wire logic busy,
	input wire logic in_ready
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	logic rc, wc, rr, wr9, bw;
	assign rc = sfr_req.rd && sfr_req.addr == 8'h92;
	assign wc = sfr_req.wr && sfr_req.addr == 8'h92;
	assign rr = sfr_req.rd && sfr_req.addr == 8'h91;
	assign wr9 = sfr_req.wr && sfr_req.addr == 8'h91;
	assign bw = sfr_req.wr && sfr_req.addr == 8'h93;
	upper_zero_a: assert property (rc |=> sfr_rdata[7:5] == 3'h0)
		else $error("control top bits set");
	ctl_readback_a: assert property (wc ##1 rc |=> sfr_rdata == ($past(sfr_req.wdata, 2) & 8'h17))
		else $error("control readback wrong");
	ptr_step_a: assert property (rc ##1 (rr || wr9) ##1 rc |=> sfr_rdata[1:0] == $past(sfr_rdata[1:0], 2) + 2'h1)
		else $error("pointer did not advance");
	init_value_a: assert property (wc && sfr_req.wdata[3] && !busy ##1 rr |=> sfr_rdata == {8{$past(sfr_req.wdata[2], 2)}})
		else $error("initial value wrong");
	port_write_a: assert property (wc && !sfr_req.wdata[3] && !busy ##1 wr9 ##1 wc && sfr_req.wdata == $past(sfr_req.wdata, 2)
		##1 rr |=> sfr_rdata == $past(sfr_req.wdata, 3))
		else $error("result byte not overwritten");
	byte_alias_a: assert property (wc && sfr_req.wdata[4] && !sfr_req.wdata[3] && sfr_req.wdata[1:0] == 2'h0 && !busy
		##1 rr [*3] |=> sfr_rdata == $past(sfr_rdata, 2))
		else $error("short mode alias wrong");
	busy_rise_a: assert property (bw && in_ready |=> busy)
		else $error("byte write not queued");
	busy_cause_a: assert property ($rose(busy) |-> $past(bw))
		else $error("busy without byte write");
	cover property (wc ##1 rr);
	cover property (bw ##1 rr);
	cover property ($fell(busy));
endmodule
bind crcb_engine crcb_monitor crcb_monitor_i (.core_clk(core_clk), .rst(rst), .sfr_req(sfr_req),
	.sfr_rdata(sfr_rdata), .busy(busy), .in_ready(in_ready));
`default_nettype wire

// ### dv/crcb_cpu_model.sv
// processor side model issuing register accesses
`timescale 1ns/100ps
`default_nettype none
module crcb_cpu_model
	import crcb_pkg::*;
(
	// clock
	input wire logic core_clk,
	// register access
	output var crcb_sfr_req_t sfr_req,
	input wire logic [7:0] sfr_rdata,
	input wire logic in_ready
);
	initial sfr_req = '0;
	// released lines show inverted values so a stale byte never passes
	task automatic idle();
		sfr_req <= '{~sfr_req.addr, ~sfr_req.wdata, 1'b0, 1'b0};
		@(negedge core_clk);
	endtask
	// one access per edge; a full queue stalls byte writes
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		while (w && a == 8'h93 && in_ready !== 1'b1) idle();
		sfr_req <= '{a, d, w, !w};
		@(negedge core_clk);
		q = sfr_rdata;
	endtask
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// self-checking bench of the crc engine
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import crcb_pkg::*;
	logic core_clk, rst, busy, in_ready;
	crcb_sfr_req_t sfr_req;
	logic [7:0] sfr_rdata, q;
	logic [7:0] e32 [4] = '{8'h90, 8'h20, 8'h46, 8'hf9};
	logic [7:0] bs [5] = '{8'h00, 8'h00, 8'haa, 8'hbb, 8'hcc};
	int fail_count = 0;
	int num_checks = 0;
	crcb_engine crcb_engine_i (.core_clk(core_clk), .rst(rst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
		.busy(busy), .in_ready(in_ready));
	crcb_cpu_model crcb_cpu_model_i (.core_clk(core_clk), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
		.in_ready(in_ready));
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		num_checks++;
		if (s !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		crcb_cpu_model_i.acc(1'b1, a, d, q);
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
		crcb_cpu_model_i.acc(1'b0, a, 8'h00, q);
		chk($sformatf("reg %h", a), q, e);
	endtask
	// bounded wait, the queue folds one byte per cycle
	task automatic drain();
		crcb_cpu_model_i.idle();
		for (int i = 0; i < 20 && busy !== 1'b0; i++) crcb_cpu_model_i.idle();
		chk("busy", {7'h00, busy}, 8'h00);
	endtask
	task automatic print_verdict();
		if (fail_count == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#20000;
		fail_count++;
		print_verdict();
	end
	initial begin
		rst = 1'b1;
		repeat (4) @(posedge core_clk);
		@(negedge core_clk);
		rst = 1'b0;
		chk("busy", {7'h00, busy}, 8'h00);
		chk("in_ready", {7'h00, in_ready}, 8'h01);
		rd_reg(8'h92, 8'h00);
		wr_reg(8'h92, 8'hff);
		rd_reg(8'h92, 8'h17);
		wr_reg(8'h92, 8'h0c);
		wr_reg(8'h93, 8'h63);
		foreach (e32[i]) rd_reg(8'h91, e32[i]);
		rd_reg(8'h92, 8'h04);
		rd_reg(8'h91, 8'h90);
		rd_reg(8'h92, 8'h05);
		wr_reg(8'h93, 8'h7d);
		wr_reg(8'h92, 8'h08);
		rd_reg(8'h91, 8'h00);
		wr_reg(8'h92, 8'h00);
		wr_reg(8'h91, 8'h5a);
		wr_reg(8'h92, 8'h00);
		rd_reg(8'h91, 8'h5a);
		wr_reg(8'h92, 8'h0c);
		foreach (bs[i]) wr_reg(8'h93, bs[i]);
		drain();
		foreach (e32[i]) rd_reg(8'h91, 8'({8'hbc, 8'h29, 8'hd1, 8'h78} >> (8 * (3 - i))));
		wr_reg(8'h92, 8'h1c);
		for (int i = 2; i < 5; i++) wr_reg(8'h93, bs[i]);
		drain();
		wr_reg(8'h92, 8'h10);
		for (int i = 0; i < 4; i++) rd_reg(8'h91, i[0] ? 8'h6c : 8'hf6);
		crcb_cpu_model_i.idle();
		print_verdict();
	end
endmodule
`default_nettype wire
